/* File: shared/pos_word_pkg.sv */
package pos_word_pkg;
    // Command word field positions
    localparam int CW_WIDTH        = 16;
    localparam int BIT_ENABLE_OP   = 3;
    localparam int BIT_STOP_N      = 4;
    localparam int BIT_HOLD_N      = 5;
    localparam int BIT_TOGGLE      = 6;
    localparam int BIT_ACK         = 7;
    localparam int BIT_JOG_POS     = 8;
    localparam int BIT_JOG_NEG     = 9;
    localparam int BIT_GUIDE       = 10;
    localparam int BIT_REF         = 11;
    localparam int BIT_FUNC_LO     = 12;
    localparam int BIT_FUNC_MID    = 13;
    localparam int BIT_CONT        = 14;
    localparam int BIT_FUNC_HI     = 15;
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam int POS_WIDTH       = 32;

    // Motion function select codes (bits 15,13,12)
    typedef enum logic [2:0] {
        FN_ABS      = 3'b000,
        FN_REL_ACT  = 3'b001,
        FN_REL_TGT  = 3'b010,
        FN_SPEED    = 3'b011,
        FN_GEAR     = 3'b100,
        FN_MARK_POS = 3'b101,
        FN_MARK_SRC = 3'b110,
        FN_RESERVED = 3'b111
    } func_e;

    // Motion states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_RUN      = 3'b001,
        ST_HOLD     = 3'b010,
        ST_QSTOP    = 3'b011,
        ST_RSTOP    = 3'b100,
        ST_JOG      = 3'b101,
        ST_JOGSTOP  = 3'b110,
        ST_REF      = 3'b111
    } mstate_e;
endpackage

/* File: hdl/edge_capture.sv */
`timescale 1ns/100ps
// Two-stage synchroniser plus edge detect on the synchronised level
module edge_capture (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic level_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_s;
    sync_s s_reg;
    sync_s s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next      = s_reg;
        s_next.meta = level_i;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.sync;
    assign rise_o  = s_reg.sync & ~s_reg.last;
    assign fall_o  = ~s_reg.sync & s_reg.last;
endmodule

/* File: hdl/positioning_control_word_decoder.sv */
`timescale 1ns/100ps
// Function
// - Enable cleared: stop ramp, ready state
// - Bit 4 set: orders start on bit-6 edge
// - Bit 4 cleared: fast stop, discard order
// - Bit 5 cleared: ramp, hold, resume later
// - Speed/gearbox: bit 5 clear terminates order
// - Every bit-6 edge releases one order; code only with bit 4 set, function not 111, in idle, run or hold
// - Bit 7 rising edge acknowledges error
// - Error held until eliminated, then disable
// - Bit 8 jogs positive when allowed
// - Bit 9 jogs negative when allowed
// - Jog bit cleared: jog brake, enabled
// - Bit 10 clear: word changes ignored
// - Bit 10 clear: digital inputs decoupled
// - Bit 11 rise starts referencing, clears flag
// - Bit 11 cleared aborts referencing, stop
// - Bits 15,13,12 select motion function
// - Relative adds actual, additive adds target
// - Mark search moves; mark order queued
// - Bit 14 resets positions per order
// - Report bit 12 follows accepted toggle
// - Report bit 11 only when reference valid
module positioning_control_word_decoder (
    input  wire logic                     ref_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic [15:0]              drive_command_word_i,
    input  wire logic [31:0]              cmd_position_i,
    input  wire logic [31:0]              actual_position_i,
    input  wire logic                     speed_zero_i,
    input  wire logic                     ramp_done_i,
    input  wire logic                     order_accepted_i,
    input  wire logic                     ref_done_i,
    input  wire logic                     error_present_i,
    input  wire logic                     error_cleared_i,
    input  wire logic                     mark_seen_i,
    output logic [2:0]                    motion_state_o,
    output logic [2:0]                    motion_func_o,
    output logic [31:0]                   target_position_o,
    output logic                          order_strobe_o,
    output logic                          reset_positions_o,
    output logic                          mark_order_queued_o,
    output logic                          error_state_o,
    output logic                          switch_on_disable_o,
    output logic                          ready_for_operation_o,
    output logic                          fieldbus_guiding_o,
    output logic                          inputs_coupled_o,
    output logic                          report_ack_o,
    output logic                          report_ref_set_o
);
    // Synchronised command word bits and edges (word comes from another domain)
    logic [15:0] cw;
    logic [15:0] cw_rise;
    logic [15:0] cw_fall;

    genvar g;
    generate
        for (g = 0; g < pos_word_pkg::CW_WIDTH; g++) begin : g_sync
            edge_capture u_cap (
                .ref_clk_i (ref_clk_i),
                .resetn_i  (resetn_i),
                .level_i   (drive_command_word_i[g]),
                .level_o   (cw[g]),
                .rise_o    (cw_rise[g]),
                .fall_o    (cw_fall[g])
            );
        end
    endgenerate

    typedef struct packed {
        pos_word_pkg::mstate_e st;
        pos_word_pkg::func_e   func;
        logic [31:0]           target;
        logic                  strobe;
        logic                  rst_pos;
        logic                  mark_q;
        logic                  err;
        logic                  son_dis;
        logic                  ack;
        logic                  ref_set;
        logic                  ack_wait;
    } dec_s;

    dec_s s_reg;
    dec_s s_next;

    logic                  guide;
    logic                  enabled;
    logic                  toggle_ev;
    pos_word_pkg::func_e   sel_func;
    logic                  run_ok;

    // Guiding gates every decoded event except bit 10 itself and the bit-3 release of son_dis
    assign guide     = cw[pos_word_pkg::BIT_GUIDE];
    assign enabled   = guide & cw[pos_word_pkg::BIT_ENABLE_OP];
    assign toggle_ev = guide & (cw_rise[pos_word_pkg::BIT_TOGGLE]
                              | cw_fall[pos_word_pkg::BIT_TOGGLE]);
    assign sel_func  = pos_word_pkg::func_e'({cw[pos_word_pkg::BIT_FUNC_HI],
                                              cw[pos_word_pkg::BIT_FUNC_MID],
                                              cw[pos_word_pkg::BIT_FUNC_LO]});

    // Motion decode is live only when enabled and clear of both error latches
    assign run_ok    = enabled & ~s_reg.err & ~s_reg.son_dis;

    // Main decode: priority is disable and error latches, then fast stop, then orders
    always_comb begin
        s_next         = s_reg;
        s_next.strobe  = 1'b0;
        s_next.rst_pos = 1'b0;
        // Acknowledge follows toggle level once motion logic accepted it
        if (s_reg.ack_wait && order_accepted_i) begin
            s_next.ack      = cw[pos_word_pkg::BIT_TOGGLE];
            s_next.ack_wait = 1'b0;
        end
        // Error handling: acknowledge arms, elimination releases
        if (error_present_i && !s_reg.err) begin
            s_next.err = 1'b1;
        end else if (s_reg.err && !s_reg.son_dis && guide
                     && cw_rise[pos_word_pkg::BIT_ACK]) begin
            s_next.son_dis = 1'b1;
        end
        // A still-present error outranks the elimination report
        if (s_reg.err && s_reg.son_dis && error_cleared_i && !error_present_i) begin
            s_next.err = 1'b0;
        end
        if (!s_reg.err && s_reg.son_dis && !cw[pos_word_pkg::BIT_ENABLE_OP]) begin
            s_next.son_dis = 1'b0;
        end
        if (!run_ok) begin
            // Disable operation rides the stop ramp down
            if (s_reg.st != pos_word_pkg::ST_IDLE) begin
                s_next.st = ramp_done_i ? pos_word_pkg::ST_IDLE
                                        : pos_word_pkg::ST_RSTOP;
            end
        end else begin
            case (s_reg.st)
                pos_word_pkg::ST_IDLE: begin
                    if (cw_rise[pos_word_pkg::BIT_REF]) begin
                        s_next.st      = pos_word_pkg::ST_REF;
                        s_next.ref_set = 1'b0;
                    end else if (toggle_ev && cw[pos_word_pkg::BIT_STOP_N]
                                 && sel_func != pos_word_pkg::FN_RESERVED) begin
                        s_next.st = pos_word_pkg::ST_RUN;
                    end else if (speed_zero_i && (cw[pos_word_pkg::BIT_JOG_POS]
                                 ^ cw[pos_word_pkg::BIT_JOG_NEG])) begin
                        s_next.st = pos_word_pkg::ST_JOG;
                    end
                end
                pos_word_pkg::ST_RUN: begin
                    if (!cw[pos_word_pkg::BIT_STOP_N]) begin
                        s_next.st = pos_word_pkg::ST_QSTOP;
                    end else if (!cw[pos_word_pkg::BIT_HOLD_N]) begin
                        if (s_reg.func == pos_word_pkg::FN_SPEED
                            || s_reg.func == pos_word_pkg::FN_GEAR) begin
                            s_next.st = pos_word_pkg::ST_RSTOP;
                        end else begin
                            s_next.st = pos_word_pkg::ST_HOLD;
                        end
                    end
                end
                pos_word_pkg::ST_HOLD: begin
                    if (!cw[pos_word_pkg::BIT_STOP_N]) begin
                        s_next.st = pos_word_pkg::ST_QSTOP;
                    end else if (cw[pos_word_pkg::BIT_HOLD_N]) begin
                        s_next.st = pos_word_pkg::ST_RUN;
                    end
                end
                pos_word_pkg::ST_QSTOP,
                pos_word_pkg::ST_RSTOP,
                pos_word_pkg::ST_JOGSTOP: begin
                    if (ramp_done_i) begin
                        s_next.st = pos_word_pkg::ST_IDLE;
                    end
                end
                pos_word_pkg::ST_JOG: begin
                    if (!(cw[pos_word_pkg::BIT_JOG_POS] | cw[pos_word_pkg::BIT_JOG_NEG])) begin
                        s_next.st = pos_word_pkg::ST_JOGSTOP;
                    end
                end
                pos_word_pkg::ST_REF: begin
                    if (!cw[pos_word_pkg::BIT_REF]) begin
                        s_next.st = pos_word_pkg::ST_RSTOP;
                    end else if (ref_done_i) begin
                        s_next.st      = pos_word_pkg::ST_IDLE;
                        s_next.ref_set = 1'b1;
                    end
                end
                default: s_next.st = pos_word_pkg::ST_IDLE;
            endcase
            // A new order may also replace a running one
            if (toggle_ev && cw[pos_word_pkg::BIT_STOP_N]
                && sel_func != pos_word_pkg::FN_RESERVED
                && (s_reg.st == pos_word_pkg::ST_IDLE || s_reg.st == pos_word_pkg::ST_RUN
                    || s_reg.st == pos_word_pkg::ST_HOLD)) begin
                s_next.func     = sel_func;
                s_next.strobe   = 1'b1;
                s_next.ack_wait = 1'b1;
                s_next.rst_pos  = cw[pos_word_pkg::BIT_CONT];
                s_next.mark_q   = (sel_func == pos_word_pkg::FN_MARK_POS);
                if (sel_func == pos_word_pkg::FN_REL_ACT) begin
                    s_next.target = cmd_position_i + actual_position_i;
                end else if (sel_func == pos_word_pkg::FN_REL_TGT) begin
                    s_next.target = cmd_position_i + s_reg.target;
                end else begin
                    s_next.target = cmd_position_i;
                end
                if (s_reg.st != pos_word_pkg::ST_IDLE) begin
                    s_next.st = pos_word_pkg::ST_RUN;
                end
            end
        end
        // Queued mark order releases once the search sees the mark;
        // a new order in the same cycle wins over the release
        if (s_reg.mark_q && mark_seen_i && !s_next.strobe) begin
            s_next.mark_q = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign motion_state_o        = s_reg.st;
    assign motion_func_o         = s_reg.func;
    assign target_position_o     = s_reg.target;
    assign order_strobe_o        = s_reg.strobe;
    assign reset_positions_o     = s_reg.rst_pos;
    assign mark_order_queued_o   = s_reg.mark_q;
    assign error_state_o         = s_reg.err;
    // son_dis latches the acknowledge; the disable state shows once the error is gone
    assign switch_on_disable_o   = s_reg.son_dis & ~s_reg.err;
    assign ready_for_operation_o = (s_reg.st == pos_word_pkg::ST_IDLE) & ~enabled;
    assign fieldbus_guiding_o    = guide;
    assign inputs_coupled_o      = guide;
    assign report_ack_o          = s_reg.ack;
    assign report_ref_set_o      = s_reg.ref_set;

    // Order strobe only after a toggle edge seen while guided
    a_toggle_strobe: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        order_strobe_o |-> $past(toggle_ev))
        else $error("order strobe without toggle");
    a_reserved_ignored: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        toggle_ev && sel_func == pos_word_pkg::FN_RESERVED |=> !order_strobe_o)
        else $error("reserved function accepted");
    a_stop_fast: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_RUN && enabled && !s_reg.err && !s_reg.son_dis
        && !cw[pos_word_pkg::BIT_STOP_N] |=> s_reg.st == pos_word_pkg::ST_QSTOP)
        else $error("no fast stop");
    a_ref_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st != pos_word_pkg::ST_REF && $past(s_reg.st) != pos_word_pkg::ST_REF
        ##1 s_reg.st == pos_word_pkg::ST_REF |-> !report_ref_set_o)
        else $error("reference flag kept");
    a_ack_level: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.ack_wait && order_accepted_i |=> report_ack_o == $past(cw[pos_word_pkg::BIT_TOGGLE]))
        else $error("ack not following toggle");
    a_guide_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !guide |=> !order_strobe_o)
        else $error("order while unguided");
    a_cont_reset: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reset_positions_o |-> order_strobe_o && $past(cw[pos_word_pkg::BIT_CONT]))
        else $error("position reset without order");
    a_ref_abort: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_REF && enabled && !s_reg.err && !s_reg.son_dis
        && !cw[pos_word_pkg::BIT_REF] |=> s_reg.st == pos_word_pkg::ST_RSTOP)
        else $error("referencing not aborted");
    // Orders, disable ramp, live-decode transitions and error acknowledge
    a_cont_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        order_strobe_o && $past(cw[pos_word_pkg::BIT_CONT]) |-> reset_positions_o)
        else $error("continuous mode reset missing");
    a_disable_ramp: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !enabled && s_reg.st != pos_word_pkg::ST_IDLE
        |=> s_reg.st == pos_word_pkg::ST_IDLE || s_reg.st == pos_word_pkg::ST_RSTOP)
        else $error("disable without stop ramp");
    a_hold_keep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_RUN && run_ok && cw[pos_word_pkg::BIT_STOP_N]
        && !cw[pos_word_pkg::BIT_HOLD_N] && !toggle_ev
        && s_reg.func != pos_word_pkg::FN_SPEED && s_reg.func != pos_word_pkg::FN_GEAR
        |=> s_reg.st == pos_word_pkg::ST_HOLD)
        else $error("temporary stop not held");
    a_hold_resume: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_HOLD && run_ok && cw[pos_word_pkg::BIT_STOP_N]
        && cw[pos_word_pkg::BIT_HOLD_N] |=> s_reg.st == pos_word_pkg::ST_RUN)
        else $error("held order not resumed");
    a_speed_stop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_RUN && run_ok && cw[pos_word_pkg::BIT_STOP_N]
        && !cw[pos_word_pkg::BIT_HOLD_N] && !toggle_ev
        && (s_reg.func == pos_word_pkg::FN_SPEED || s_reg.func == pos_word_pkg::FN_GEAR)
        |=> s_reg.st == pos_word_pkg::ST_RSTOP)
        else $error("speed order not terminated");
    a_jog_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_IDLE && run_ok && speed_zero_i && !toggle_ev
        && !cw_rise[pos_word_pkg::BIT_REF]
        && (cw[pos_word_pkg::BIT_JOG_POS] ^ cw[pos_word_pkg::BIT_JOG_NEG])
        |=> s_reg.st == pos_word_pkg::ST_JOG)
        else $error("jog not started");
    a_jog_brake: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_JOG && run_ok && !cw[pos_word_pkg::BIT_JOG_POS]
        && !cw[pos_word_pkg::BIT_JOG_NEG] |=> s_reg.st == pos_word_pkg::ST_JOGSTOP)
        else $error("jog not braked");
    a_err_ack: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.err && guide && cw_rise[pos_word_pkg::BIT_ACK] |=> s_reg.son_dis)
        else $error("error acknowledge lost");
    a_ref_done: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_reg.st == pos_word_pkg::ST_REF && run_ok && cw[pos_word_pkg::BIT_REF]
        && ref_done_i |=> report_ref_set_o)
        else $error("reference flag not set");
    a_mark_queue: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        order_strobe_o && motion_func_o == pos_word_pkg::FN_MARK_POS |-> mark_order_queued_o)
        else $error("mark order not queued");
endmodule

/* File: sim/cw_master_model.sv */
`timescale 1ns/100ps
// Automation controller side: writes the cyclic command word off the sampling edge
module cw_master_model (
    input  wire logic        ref_clk_i,
    input  wire logic        report_ack_i,
    input  wire logic        report_ref_set_i,
    output logic [15:0]      drive_command_word_o
);
    initial drive_command_word_o = 16'h0000;

    // Whole word at once, so no half-updated field is ever seen
    task automatic put(input logic [15:0] w);
        @(negedge ref_clk_i);
        drive_command_word_o = w;
    endtask

    // Waits up to 50 cycles for the drive's confirmation, then toggles anyway; bit 5 stays as the caller set it
    task automatic toggle(output bit ok);
        int n;
        n = 0;
        while ((report_ack_i !== drive_command_word_o[6] || report_ref_set_i !== 1'b1)
               && n < 50) begin
            @(negedge ref_clk_i);
            n++;
        end
        ok = (n < 50);
        put(drive_command_word_o ^ 16'h0040);
    endtask
endmodule

/* File: sim/positioning_control_word_decoder_tb_top.sv */
`timescale 1ns/100ps
module positioning_control_word_decoder_tb_top;
    localparam logic [15:0] W_RUN = 16'h0438; // Enabled, no stops, guiding on
    logic        ref_clk_i, resetn_i, speed_zero_i, ramp_done_i, order_accepted_i;
    logic        ref_done_i, error_present_i, error_cleared_i, mark_seen_i, hit;
    logic [15:0] drive_command_word_i;
    logic [31:0] cmd_position_i, actual_position_i, target_position_o, tgt;
    logic [2:0]  motion_state_o, motion_func_o;
    logic        order_strobe_o, reset_positions_o, mark_order_queued_o, error_state_o;
    logic        switch_on_disable_o, ready_for_operation_o, fieldbus_guiding_o;
    logic        inputs_coupled_o, report_ack_o, report_ref_set_o;
    int          num_errors, check_count;

    cw_master_model cw_master_model_inst (.ref_clk_i(ref_clk_i), .report_ack_i(report_ack_o),
        .report_ref_set_i(report_ref_set_o), .drive_command_word_o(drive_command_word_i));

    positioning_control_word_decoder positioning_control_word_decoder_inst (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .drive_command_word_i(drive_command_word_i),
        .cmd_position_i(cmd_position_i), .actual_position_i(actual_position_i),
        .speed_zero_i(speed_zero_i), .ramp_done_i(ramp_done_i),
        .order_accepted_i(order_accepted_i), .ref_done_i(ref_done_i),
        .error_present_i(error_present_i), .error_cleared_i(error_cleared_i),
        .mark_seen_i(mark_seen_i), .motion_state_o(motion_state_o),
        .motion_func_o(motion_func_o), .target_position_o(target_position_o),
        .order_strobe_o(order_strobe_o), .reset_positions_o(reset_positions_o),
        .mark_order_queued_o(mark_order_queued_o), .error_state_o(error_state_o),
        .switch_on_disable_o(switch_on_disable_o),
        .ready_for_operation_o(ready_for_operation_o),
        .fieldbus_guiding_o(fieldbus_guiding_o), .inputs_coupled_o(inputs_coupled_o),
        .report_ack_o(report_ack_o), .report_ref_set_o(report_ref_set_o));

    // 125 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Keeps the toggle level so that no stray order edge is produced
    task automatic setw(input logic [15:0] x);
        cw_master_model_inst.put((drive_command_word_i & 16'h0040) | x);
    endtask

    task automatic put(input logic [15:0] x);
        cw_master_model_inst.put(x);
    endtask

    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (motion_state_o !== s && n < 20) begin
            tick(1);
            n++;
        end
        chk(32'(motion_state_o), 32'(s));
    endtask

    // The strobe lasts one cycle, so every falling edge is looked at
    task automatic wait_strobe();
        hit = 1'b0;
        for (int n = 0; n < 8 && hit !== 1'b1; n++) begin
            tick(1);
            hit = order_strobe_o;
        end
    endtask

    task automatic brake_done();
        ramp_done_i = 1'b1;
        wait_state(pos_word_pkg::ST_IDLE);
        ramp_done_i = 1'b0;
    endtask

    // One full order: toggle, strobe, decode, acceptance echo
    task automatic order(input logic [2:0] f, input logic [15:0] extra);
        bit ok;
        setw(W_RUN | extra | {f[2], 1'b0, f[1:0], 12'h000});
        cw_master_model_inst.toggle(ok);
        chk(32'(ok), 1);
        wait_strobe();
        chk(32'(hit), 1);
        chk(32'(motion_state_o), 32'(pos_word_pkg::ST_RUN));
        chk(32'(motion_func_o), 32'(f));
        chk(32'(reset_positions_o), 32'(extra[14]));
        if (f < 3'd3) begin
            tgt = (f == 3'd0) ? cmd_position_i : cmd_position_i + ((f == 3'd1) ? actual_position_i : tgt);
            chk(target_position_o, tgt);
        end
        order_accepted_i = 1'b1;
        tick(1);
        order_accepted_i = 1'b0;
        tick(2);
        chk(32'(report_ack_o), 32'(drive_command_word_i[6]));
    endtask

    task automatic t_guide();
        chk(32'(ready_for_operation_o), 1);
        put(16'h0078);
        wait_strobe();
        chk(32'(hit), 0);
        chk(32'(fieldbus_guiding_o), 0);
        chk(32'(inputs_coupled_o), 0);
        put(16'h0038);
        $display("guide test done");
    endtask

    task automatic t_ref();
        put(W_RUN);
        tick(5);
        chk(32'(inputs_coupled_o), 1);
        put(W_RUN | 16'h0800);
        wait_state(pos_word_pkg::ST_REF);
        chk(32'(report_ref_set_o), 0);
        put(W_RUN);
        wait_state(pos_word_pkg::ST_RSTOP);
        brake_done();
        put(W_RUN | 16'h0800);
        wait_state(pos_word_pkg::ST_REF);
        chk(32'(report_ref_set_o), 0);
        ref_done_i = 1'b1;
        tick(4);
        chk(32'(report_ref_set_o), 1);
        // Restart with the flag set, so that its clearing is really seen
        ref_done_i = 1'b0;
        put(W_RUN);
        tick(4);
        put(W_RUN | 16'h0800);
        wait_state(pos_word_pkg::ST_REF);
        chk(32'(report_ref_set_o), 0);
        ref_done_i = 1'b1;
        tick(4);
        chk(32'(report_ref_set_o), 1);
        put(W_RUN);
        wait_state(pos_word_pkg::ST_IDLE);
        $display("reference test done");
    endtask

    task automatic t_orders();
        cmd_position_i = 32'h0000_0200;
        actual_position_i = 32'h0000_0500;
        for (int f = 0; f < 7; f++) begin
            order(3'(f), (f == 3) ? 16'h4000 : 16'h0000);
            if (f == 5) begin
                chk(32'(mark_order_queued_o), 1);
                mark_seen_i = 1'b1;
                tick(1);
                mark_seen_i = 1'b0;
                tick(2);
                chk(32'(mark_order_queued_o), 0);
            end
        end
        $display("orders test done");
    endtask

    task automatic t_stops();
        put(drive_command_word_i & 16'hffdf);
        wait_state(pos_word_pkg::ST_HOLD);
        put(drive_command_word_i | 16'h0020);
        wait_state(pos_word_pkg::ST_RUN);
        order(3'd3, 16'h0000);
        put(drive_command_word_i & 16'hffdf);
        wait_state(pos_word_pkg::ST_RSTOP);
        brake_done();
        order(3'd0, 16'h0000);
        put(drive_command_word_i & 16'hffef);
        wait_state(pos_word_pkg::ST_QSTOP);
        brake_done();
        order(3'd0, 16'h0000);
        put(drive_command_word_i & 16'hfff7);
        wait_state(pos_word_pkg::ST_RSTOP);
        brake_done();
        chk(32'(ready_for_operation_o), 1);
        $display("stops test done");
    endtask

    task automatic t_reserved();
        setw(W_RUN | 16'hb000);
        for (int i = 0; i < 2; i++) begin
            put(drive_command_word_i ^ 16'h0040);
            wait_strobe();
            chk(32'(hit), 0);
        end
        chk(32'(motion_state_o), 32'(pos_word_pkg::ST_IDLE));
        $display("reserved test done");
    endtask

    task automatic t_jog();
        speed_zero_i = 1'b1;
        for (int j = 8; j < 10; j++) begin
            setw(W_RUN | (16'h0001 << j));
            wait_state(pos_word_pkg::ST_JOG);
            setw(W_RUN);
            wait_state(pos_word_pkg::ST_JOGSTOP);
            brake_done();
        end
        $display("jog test done");
    endtask

    task automatic t_error();
        error_present_i = 1'b1;
        tick(4);
        chk(32'(error_state_o), 1);
        setw(W_RUN | 16'h0080);
        tick(6);
        chk(32'(error_state_o), 1);
        chk(32'(switch_on_disable_o), 0);
        error_present_i = 1'b0;
        error_cleared_i = 1'b1;
        tick(4);
        chk(32'(error_state_o), 0);
        chk(32'(switch_on_disable_o), 1);
        $display("error test done");
    endtask

    task automatic test_done();
        $display("Checks made: %0d, mismatches: %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        num_errors++;
        test_done();
    end

    initial begin
        num_errors = 0;
        check_count = 0;
        {resetn_i, speed_zero_i, ramp_done_i, order_accepted_i, ref_done_i} = 5'h00;
        {error_present_i, error_cleared_i, mark_seen_i} = 3'h0;
        cmd_position_i = 32'h0000_0000;
        actual_position_i = 32'h0000_0000;
        tgt = 32'h0000_0000;
        repeat (4) @(posedge ref_clk_i);
        tick(1);
        resetn_i = 1'b1;
        tick(2);
        t_guide();
        t_ref();
        t_orders();
        t_stops();
        t_reserved();
        t_jog();
        t_error();
        test_done();
    end
endmodule
